/* dv/drs_host.sv */
// Host model: drives the command bus and the hardware reset pin of the sequencer.
// Assumes a classic Wishbone slave on one rising-edge clock.
`timescale 1ns/10ps
module drs_host (
  input  wire logic        mclk,
  input  wire logic        wb_ack_o,
  input  wire logic [31:0] wb_dat_o,
  output logic             hw_reset_pin_n,
  output logic             wb_cyc_i,
  output logic             wb_stb_i,
  output logic             wb_we_i,
  output logic [3:0]       wb_adr_i,
  output logic [3:0]       wb_sel_i,
  output logic [31:0]      wb_dat_i
);
  initial begin
    hw_reset_pin_n = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'hF;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
  end
  // The request stands until ack is sampled; released we, address and data lines carry the inverse (sel stays 4'hF) so stale data never looks live.
  task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic ok);
    @(posedge mclk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    @(posedge mclk);
    while (wb_ack_o !== 1'b1) @(posedge mclk);
    ok = (wb_ack_o === 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= ~we;
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
  endtask
  // Holds the pin low for a count; only a count of at least the standby limit leaves deep standby.
  task automatic pin_low(input int cyc);
    @(posedge mclk);
    hw_reset_pin_n <= 1'b0;
    repeat (cyc) @(posedge mclk);
    hw_reset_pin_n <= 1'b1;
  endtask
endmodule

/* dv/tb_top.sv */
// Bench for the reset and standby sequencer: straps, reset periods, commands, standby exit.
// Assumes the host model owns the bus and the pin; the straps come from this bench.
`timescale 1ns/10ps
module tb_top;
  import drs_pkg::*;
  localparam int unsigned RST_N = 20;
  localparam int unsigned SET_N = 40;
  localparam int unsigned DSB_N = 30;
  logic        mclk;
  logic        rst_b;
  logic [2:0]  strap;
  logic        hw_reset_pin_n;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [3:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        busy;
  logic        otp_load;
  logic [4:0]  pan;
  logic        deep_standby;
  drs_supply_t supply_mode;
  logic [31:0] q;
  int          mismatches;
  int          compares;
  int          cycles;
  int          n;
  int          i;
  integer      seed;
  drs_seq #(.RESET_CYCLES(RST_N), .SETTLE_CYCLES(SET_N), .DSTB_CYCLES(DSB_N)) DUT (
    .mclk(mclk), .rst_b(rst_b), .hw_reset_pin_n(hw_reset_pin_n), .pos_supply_strap(strap[2]),
    .neg_supply_strap(strap[1]), .fourth_supply_strap(strap[0]), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .busy(busy), .otp_config_store_load(otp_load), .source_out_en(pan[4]),
    .vcom_en(pan[3]), .gamma_ref_en(pan[2]), .gate_panel_en(pan[1]), .tear_pwm_en(pan[0]),
    .deep_standby(deep_standby), .supply_mode(supply_mode));
  drs_host host (
    .mclk(mclk), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .hw_reset_pin_n(hw_reset_pin_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i));
  function automatic logic [1:0] supply_exp(input logic [2:0] s);
    if (s[2] & s[1]) begin
      supply_exp = s[0] ? DRS_SUP_FOUR : DRS_SUP_THREE;
    end else begin
      supply_exp = DRS_SUP_TWO;
    end
  endfunction
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run;
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
    logic ok;
    host.xfer(we, a, d, q, ok);
    check("wb_ack", 32'h1, {31'h0, ok});
  endtask
  task automatic wait_ready(input int lim);
    for (n = 0; n < lim && busy !== 1'b0; n++) tick(1);
    check("busy_low", 32'h0, {31'h0, busy});
  endtask
  task automatic power_up(input logic [2:0] s);
    @(posedge mclk);
    strap <= s;
    rst_b <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_b <= 1'b1;
  endtask
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    rst_b = 1'b0;
    strap = 3'b000;
    seed = 32'h2f581f59;
    for (i = 0; i < 8; i++) begin
      power_up(i[2:0]);
      tick(RST_N + SET_N - 4);
      check("busy_por", 32'h1, {31'h0, busy});
      check("panel_rst", 32'h0, {27'h0, pan});
      wait_ready(20);
      if (i[2:1] != 2'b01) check("supply", {30'h0, supply_exp(i[2:0])}, {30'h0, supply_mode});
      bus(1'b0, ADDR_SUPPLY, 32'h0);
      if (i[2:1] != 2'b01) check("supply_reg", {30'h0, supply_exp(i[2:0])}, q);
    end
    host.pin_low(4);
    tick(2);
    check("busy_pin", 32'h1, {31'h0, busy});
    bus(1'b1, ADDR_CMD, {16'h0, DSTB_PARAM, CMD_DSTB});
    wait_ready(30);
    bus(1'b0, ADDR_STATUS, 32'h0);
    check("status", 32'h2A, {26'h0, q[5:0]});
    bus(1'b0, 4'hC, 32'hFFFF_FFFF);
    check("unmapped", 32'h0, q);
    bus(1'b1, ADDR_CMD, {24'h0, CMD_SLEEP_OUT});
    // Sampling starts one step after the ack edge, so the first load cycle is counted too.
    tick(0);
    for (n = 0, i = 0; n < 30; n++) begin
      if (otp_load === 1'b1) i++;
      tick(1);
    end
    check("otp_cycles", OTP_LOAD_CYC + 1, i);
    check("panel_on", 32'h0C, {27'h0, pan});
    bus(1'b1, ADDR_CMD, {24'h0, CMD_DISPLAY_OFF});
    tick(2);
    check("panel_off", 32'h0C, {27'h0, pan});
    q = $random(seed);
    if (q[7:0] == DSTB_PARAM) q[7:0] = 8'h02;
    bus(1'b1, ADDR_CMD, {16'h0, q[7:0], CMD_DSTB});
    tick(2);
    check("dstb_bad_param", 32'h0, {31'h0, deep_standby});
    bus(1'b1, ADDR_CMD, {24'h0, CMD_SLEEP_IN});
    tick(32);
    bus(1'b1, ADDR_CMD, {16'h0, DSTB_PARAM, CMD_DSTB});
    tick(2);
    check("dstb_enter", 32'h1, {31'h0, deep_standby});
    q = $random(seed);
    host.pin_low(5 + q[3:0]);
    tick(5);
    check("dstb_short", 32'h1, {31'h0, deep_standby});
    host.pin_low(DSB_N + 10);
    tick(4);
    check("dstb_exit", 32'h0, {31'h0, deep_standby});
    check("busy_exit", 32'h1, {31'h0, busy});
    wait_ready(30);
    bus(1'b1, ADDR_CMD, {24'h0, CMD_SLEEP_OUT});
    tick(30);
    host.pin_low(4);
    tick(3);
    check("panel_pin", 32'h0, {27'h0, pan});
    complete_run();
  end
  initial begin
    mismatches = 0;
    compares = 0;
    cycles = 0;
  end
endmodule

/* rtl/drs_pkg.sv */
// Constants shared by the display reset and standby sequencer.
// Assumes a 25 MHz core clock and a classic Wishbone register port.
package drs_pkg;
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned RESET_PERIOD_US = 1000;
  localparam int unsigned OSC_SETTLE_US   = 20000;
  localparam int unsigned DSTB_EXIT_US    = 3000;
  localparam int unsigned RESET_CYC       = (CLK_HZ / 1000000) * RESET_PERIOD_US;
  localparam int unsigned SETTLE_CYC      = (CLK_HZ / 1000000) * OSC_SETTLE_US;
  localparam int unsigned DSTB_CYC        = (CLK_HZ / 1000000) * DSTB_EXIT_US + 1;
  localparam int unsigned OTP_LOAD_CYC    = 16;
  localparam int unsigned CNT_W           = 20;

  localparam logic [7:0] CMD_DISPLAY_OFF  = 8'h28;
  localparam logic [7:0] CMD_SLEEP_IN     = 8'h10;
  localparam logic [7:0] CMD_SLEEP_OUT    = 8'h11;
  localparam logic [7:0] CMD_DSTB         = 8'h4F;
  localparam logic [7:0] DSTB_PARAM       = 8'h01;

  localparam logic [3:0] ADDR_CMD    = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_SUPPLY = 4'h8;

  localparam int unsigned ST_BUSY      = 0;
  localparam int unsigned ST_SLEEP     = 1;
  localparam int unsigned ST_DSTB      = 2;
  localparam int unsigned ST_DISP_OFF  = 3;
  localparam int unsigned ST_OTP_LOAD  = 4;
  localparam int unsigned ST_POR_DONE  = 5;
  localparam int unsigned CMD_PARAM_LSB = 8;

  typedef enum logic [1:0] {
    DRS_SUP_TWO   = 2'b00,
    DRS_SUP_THREE = 2'b01,
    DRS_SUP_FOUR  = 2'b10
  } drs_supply_t;

  typedef enum logic [2:0] {
    DRS_RESET   = 3'b000,
    DRS_SETTLE  = 3'b001,
    DRS_SLEEP   = 3'b010,
    DRS_ACTIVE  = 3'b011,
    DRS_OTP     = 3'b100,
    DRS_DSTB    = 3'b101
  } drs_state_t;
endpackage

/* rtl/drs_seq.sv */
// Reset, power-up and deep standby sequencer of the display driver.
// Assumes mclk is the internal oscillator and the host keeps its own waits.
// Operation
// - A low level on the hardware reset pin starts the reset function.
// - The reset period lasts at least one millisecond after reset.
// - During the reset period commands are refused; host must not send any.
// - In reset, source, VCOM, gamma, gate and tearing outputs are held low.
// - Only a reset pulse longer than 3 ms exits deep standby.
// - Command 4Fh with parameter 01h enters deep standby.
// - Sleep out reloads the one-time configuration and runs power-on.
// - Straps 00b or 10b give two supplies; 11b gives three or four.
`timescale 1ns/10ps
module drs_seq
  import drs_pkg::*;
#(
  parameter int unsigned RESET_CYCLES  = RESET_CYC,
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC,
  parameter int unsigned DSTB_CYCLES   = DSTB_CYC
) (
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  input  wire logic                 hw_reset_pin_n,
  input  wire logic                 pos_supply_strap,
  input  wire logic                 neg_supply_strap,
  input  wire logic                 fourth_supply_strap,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      busy,
  output logic                      otp_config_store_load,
  output logic                      source_out_en,
  output logic                      vcom_en,
  output logic                      gamma_ref_en,
  output logic                      gate_panel_en,
  output logic                      tear_pwm_en,
  output logic                      deep_standby,
  output drs_pkg::drs_supply_t      supply_mode
);
  import drs_pkg::*;

  typedef struct packed {
    drs_state_t          state;
    logic [CNT_W-1:0]    cnt;
    logic [CNT_W-1:0]    low_cnt;
    logic                por;
    logic                disp_off;
    logic                sleep;
    logic                dstb;
    logic                ack;
    logic [31:0]         rdata;
    logic                straps_ok;
    drs_supply_t         supply;
    logic                cmd_ok;
  } drs_st_t;

  drs_st_t r;
  drs_st_t next_r;
  logic    pin_n_s;
  logic    rst_meta;
  logic    rst_int_b;
  logic [2:0] straps_s;

  // The pin is sampled twice so a slow edge never reaches the counters directly.
  // The pin idles high, so the synchroniser resets to high and no false pulse follows reset.
  drs_sync #(.W(1), .INIT(1'b1)) u_pin_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   (hw_reset_pin_n),
    .dout  (pin_n_s)
  );

  drs_sync #(.W(3), .INIT(3'h0)) u_strap_sync (
    .mclk  (mclk),
    .rst_b (rst_b),
    .din   ({pos_supply_strap, neg_supply_strap, fourth_supply_strap}),
    .dout  (straps_s)
  );

  // Internal reset falls with rst_b and rises two clock edges after rst_b is released; the pin does not drive it.
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta  <= 1'b0;
      rst_int_b <= 1'b0;
    end else begin
      rst_meta  <= 1'b1;
      rst_int_b <= rst_meta;
    end
  end

  function automatic drs_supply_t decode_supply(input logic [2:0] s);
    if (s[2:1] == 2'b11) begin
      decode_supply = s[0] ? DRS_SUP_FOUR : DRS_SUP_THREE;
    end else begin
      decode_supply = DRS_SUP_TWO;
    end
  endfunction

  function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
    hit = (a == b);
  endfunction

  logic req;
  assign req = wb_cyc_i && wb_stb_i && !r.ack;

  always_comb begin
    next_r     = r;
    next_r.ack = req;
    next_r.cmd_ok = 1'b0;
    if (r.cnt != '0) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    // Count how long the synchronised pin stays low, saturating.
    if (!pin_n_s) begin
      if (r.low_cnt != {CNT_W{1'b1}}) begin
        next_r.low_cnt = r.low_cnt + 1'b1;
      end
    end else begin
      next_r.low_cnt = '0;
    end
    if (!r.straps_ok) begin
      next_r.straps_ok = 1'b1;
      next_r.supply    = decode_supply(straps_s);
    end
    if (req && !wb_we_i) begin
      next_r.rdata = '0;
      if (hit(wb_adr_i, ADDR_STATUS)) begin
        next_r.rdata[ST_BUSY]     = busy;
        next_r.rdata[ST_SLEEP]    = r.sleep;
        next_r.rdata[ST_DSTB]     = r.dstb;
        next_r.rdata[ST_DISP_OFF] = r.disp_off;
        next_r.rdata[ST_OTP_LOAD] = (r.state == DRS_OTP);
        next_r.rdata[ST_POR_DONE] = !r.por;
      end else if (hit(wb_adr_i, ADDR_SUPPLY)) begin
        next_r.rdata[1:0] = r.supply;
      end
    end
    if (req && wb_we_i && hit(wb_adr_i, ADDR_CMD) && wb_sel_i[0] && !busy) begin
      next_r.cmd_ok = 1'b1;
    end
    case (r.state)
      DRS_RESET: begin
        // Wait out the reset period before anything else.
        if (r.cnt == '0) begin
          next_r.state = r.por ? DRS_SETTLE : DRS_SLEEP;
          next_r.cnt   = CNT_W'(SETTLE_CYCLES);
        end
      end
      DRS_SETTLE: begin
        if (r.cnt == '0) begin
          next_r.state = DRS_SLEEP;
          next_r.por   = 1'b0;
        end
      end
      DRS_SLEEP, DRS_ACTIVE: begin
        if (r.cmd_ok) begin
          case (wb_dat_i[7:0])
            CMD_DISPLAY_OFF: next_r.disp_off = 1'b1;
            CMD_SLEEP_IN: begin
              next_r.sleep = 1'b1;
              next_r.state = DRS_SLEEP;
            end
            CMD_SLEEP_OUT: begin
              next_r.sleep = 1'b0;
              next_r.state = DRS_OTP;
              next_r.cnt   = CNT_W'(OTP_LOAD_CYC);
            end
            CMD_DSTB: begin
              if (wb_dat_i[CMD_PARAM_LSB +: 8] == DSTB_PARAM) begin
                next_r.dstb  = 1'b1;
                next_r.state = DRS_DSTB;
              end
            end
            default: next_r.disp_off = r.disp_off;
          endcase
        end
      end
      DRS_OTP: begin
        if (r.cnt == '0) begin
          next_r.state = DRS_ACTIVE;
        end
      end
      DRS_DSTB: begin
        // Short pulses are ignored here; only a long one wakes the part.
        if (pin_n_s && (r.low_cnt >= CNT_W'(DSTB_CYCLES))) begin
          next_r.dstb     = 1'b0;
          next_r.sleep    = 1'b1;
          next_r.disp_off = 1'b1;
          next_r.state    = DRS_RESET;
          next_r.cnt      = CNT_W'(RESET_CYCLES);
        end
      end
      default: next_r.state = DRS_RESET;
    endcase
    // An ordinary pin pulse restarts the reset period.
    if (!pin_n_s && r.state != DRS_DSTB) begin
      next_r.state    = DRS_RESET;
      next_r.cnt      = CNT_W'(RESET_CYCLES);
      next_r.sleep    = 1'b1;
      next_r.disp_off = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_int_b) begin
    if (!rst_int_b) begin
      r <= '{state: DRS_RESET, cnt: CNT_W'(RESET_CYCLES), low_cnt: '0, por: 1'b1,
             disp_off: 1'b1, sleep: 1'b1, dstb: 1'b0, ack: 1'b0, rdata: '0,
             straps_ok: 1'b0, supply: DRS_SUP_TWO, cmd_ok: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  assign busy                  = (r.state == DRS_RESET) || (r.state == DRS_SETTLE);
  assign wb_ack_o              = r.ack;
  assign wb_dat_o              = r.rdata;
  assign otp_config_store_load = (r.state == DRS_OTP);
  assign deep_standby          = r.dstb;
  assign supply_mode           = r.supply;
  // Panel drivers stay at the low rail whenever the part is busy or asleep.
  assign source_out_en = (r.state == DRS_ACTIVE) && !r.disp_off;
  assign vcom_en       = (r.state == DRS_ACTIVE);
  assign gamma_ref_en  = (r.state == DRS_ACTIVE);
  assign gate_panel_en = (r.state == DRS_ACTIVE) && !r.disp_off;
  assign tear_pwm_en   = (r.state == DRS_ACTIVE) && !r.disp_off;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_int_b);

  sequence s_dstb_cmd;
    r.cmd_ok && (wb_dat_i[7:0] == CMD_DSTB) && (wb_dat_i[CMD_PARAM_LSB +: 8] == DSTB_PARAM)
      && (r.state inside {DRS_SLEEP, DRS_ACTIVE}) && pin_n_s;
  endsequence

  property p_busy_refuse;
    (req && wb_we_i && busy) |=> !r.cmd_ok;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("Command taken while busy.");

  property p_reset_out_low;
    busy |-> !(source_out_en || vcom_en || gamma_ref_en || gate_panel_en || tear_pwm_en);
  endproperty
  a_reset_out_low: assert property (p_reset_out_low) else $error("Panel output enabled during reset.");

  property p_pin_reset;
    (!pin_n_s && r.state != DRS_DSTB) |=> (r.state == DRS_RESET) && busy;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("Reset pin did not start reset.");

  property p_reset_len;
    $rose(busy) |-> busy [*8];
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("Reset period too short.");

  property p_dstb_enter;
    s_dstb_cmd |=> deep_standby;
  endproperty
  a_dstb_enter: assert property (p_dstb_enter) else $error("Standby command not obeyed.");

  property p_dstb_short;
    (deep_standby && pin_n_s && r.low_cnt < CNT_W'(DSTB_CYCLES)) |=> deep_standby;
  endproperty
  a_dstb_short: assert property (p_dstb_short) else $error("Short pulse left standby.");

  property p_otp_load;
    (r.cmd_ok && wb_dat_i[7:0] == CMD_SLEEP_OUT && r.state inside {DRS_SLEEP, DRS_ACTIVE} && pin_n_s)
      |=> otp_config_store_load [*2];
  endproperty
  a_otp_load: assert property (p_otp_load) else $error("Sleep out did not reload.");

  property p_supply;
    r.straps_ok && straps_s[2:1] != 2'b11 |-> supply_mode == DRS_SUP_TWO || $changed(straps_s);
  endproperty
  a_supply: assert property (p_supply) else $error("Supply decode wrong.");

  property p_por_busy;
    r.por |-> busy;
  endproperty
  a_por_busy: assert property (p_por_busy) else $error("Busy dropped before settle.");
endmodule

/* rtl/drs_sync.sv */
// Two-flop synchroniser for the external pins.
// Assumes asynchronous inputs and an active-low asynchronous reset.
`timescale 1ns/10ps
module drs_sync #(
  parameter int unsigned W     = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } drs_sync_st_t;
  drs_sync_st_t r;
  drs_sync_st_t next_r;

  always_comb begin
    next_r      = r;
    next_r.meta = din;
    next_r.sync = r.meta;
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '{meta: INIT, sync: INIT};
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.sync;
endmodule
